//--- design/esb_emu_status.sv
// What this block does
// (R01) general words readable and writable as separate high and low bytes
// (R02) fetch address is code_seg base plus instr_ptr offset
// (R03) data references default to data_seg; string dest_index uses extra_seg
// (R04) references using stack_ptr or base_ptr default to stack_seg
// (R05) last fetch opcode register holds opcode of latest traced fetch
// (R06) prev_fetch_offset holds offset of latest traced fetch address
// (R07) 2 MHz timer advances while running; low half read-only
// (R08) high half of timer read-only, both halves one count
// (R09) 16-bit read-only count of valid trace frames held
// (R10) aux_carry_flag set on carry from bit 3 into bit 4
// (R11) carry_flag set on carry out of or borrow into msb
// (R12) flags_word holds nine single-bit status values
// (R13) trap_flag set puts processor into single-step mode
// (R14) halt reason bit is 1 when its condition is true
// (R15) bits 0 and 1: break_match_a or break_match_b matched
// (R16) bit 2: chained_match, both break registers in one instruction
// (R17) bit 3: unmapped_access halt on touching unmapped memory
// (R18) bit 4: operator abort request from the host
// (R19) bit 5: ready_wait_expired halt
// (R20) bit 6: hold_wait_expired halt
// (R21) bit 7: halt by ext_halt_line, driven by the outside party
// (R22) eight processor pin values readable
// (R23) at most one halt cause recorded at any time
// (R24) halt reason reads as no cause before any emulation
// (R25) flags_word layout: OF11 DF10 IF9 TF8 SF7 ZF6 AF4 PF2 CF0
`default_nettype none
module esb_emu_status (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // register bus
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [esb_pkg::ESB_AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // trace capture
   input wire logic FETCH_STROBE,
   input wire logic [7:0] FETCH_OPCODE,
   input wire logic [15:0] FETCH_OFFSET,
   input wire logic FRAME_STORE,
   input wire logic TRACE_CLEAR,
   // arithmetic operands for flag update
   input wire logic ALU_VALID,
   input wire logic [15:0] ALU_A,
   input wire logic [15:0] ALU_B,
   input wire logic ALU_SUB,
   input wire logic ALU_BYTE,
   // address formation
   input wire logic [15:0] REF_OFFSET,
   input wire logic REF_USES_STACK,
   input wire logic REF_STRING_DEST,
   output logic [19:0] FETCH_ADDR,
   output logic [19:0] DATA_ADDR,
   // halt conditions
   input wire logic BREAK_MATCH_A,
   input wire logic BREAK_MATCH_B,
   input wire logic UNMAPPED_ACCESS,
   input wire logic READY_WAIT_EXPIRED,
   input wire logic HOLD_WAIT_EXPIRED,
   input wire logic EXT_HALT_LINE,
   // processor pins
   input wire logic PIN_READY,
   input wire logic PIN_NMI,
   input wire logic PIN_TEST,
   input wire logic PIN_HOLD,
   input wire logic PIN_RESET,
   input wire logic MIN_MAX_STRAP,
   input wire logic INTERRUPT_REQUEST_PIN,
   input wire logic REQUEST_GRANT_STATUS,
   // status
   output logic EMU_RUNNING,
   output logic SINGLE_STEP
);
   import esb_pkg::*;

   typedef struct packed {
      esb_run_t run;
      logic ack;
      logic err;
      logic [31:0] prdata;
      logic [3:0][15:0] seg;
      logic [15:0] instr;
      logic [15:0] flags;
      logic [7:0] opcode;
      logic [15:0] prev_ofs;
      logic [31:0] timer;
      logic [4:0] phase;
      logic [15:0] frames;
      logic [7:0] cause;
      logic [19:0] fetch_addr;
      logic [19:0] data_addr;
   } esb_state_t;

   esb_state_t s;
   esb_state_t next_s;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [19:0] phys_addr(input logic [15:0] seg, input logic [15:0] ofs);
      phys_addr = {seg, 4'h0} + {4'h0, ofs};
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val,
                                           input logic [1:0] strb);
      merge16 = old;
      if (strb[1]) merge16[15:8] = val[15:8];
      if (strb[0]) merge16[7:0] = val[7:0];
   endfunction

   function automatic logic in_file(input logic [7:0] addr, input logic [7:0] base);
      in_file = (addr >= base) && (addr < base + ESB_FILE_SPAN) && (addr[1:0] == 2'h0);
   endfunction

   // lowest set bit wins, so only one cause is ever kept
   function automatic logic [7:0] one_cause(input logic [7:0] ev);
      one_cause = ESB_CAUSE_NONE;
      for (int i = 7; i >= 0; i--) begin
         if (ev[i]) one_cause = 8'h01 << i;
      end
   endfunction

   function automatic logic [15:0] alu_flags(input logic [15:0] old, input logic [15:0] a,
                                             input logic [15:0] b, input logic sub,
                                             input logic byte_op);
      logic [15:0] bb;
      logic [16:0] wsum;
      logic [8:0] bsum;
      logic [15:0] res;
      logic cout;
      logic ma;
      logic mb;
      logic mr;
      bb = sub ? ~b : b;
      wsum = {1'b0, a} + {1'b0, bb} + {16'h0000, sub};
      bsum = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, sub};
      res = wsum[15:0];
      cout = byte_op ? bsum[8] : wsum[16];
      ma = byte_op ? a[7] : a[15];
      mb = byte_op ? bb[7] : bb[15];
      mr = byte_op ? res[7] : res[15];
      alu_flags = old;
      alu_flags[ESB_FL_CF] = sub ? ~cout : cout; // R11
      alu_flags[ESB_FL_AF] = a[4] ^ b[4] ^ res[4]; // R10
      alu_flags[ESB_FL_ZF] = byte_op ? (res[7:0] == 8'h00) : (res == 16'h0000);
      alu_flags[ESB_FL_SF] = mr;
      alu_flags[ESB_FL_PF] = ~^res[7:0];
      alu_flags[ESB_FL_OF] = (ma == mb) && (mr != ma);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic setup_edge;
   logic first_acc;
   logic done_wr;
   logic hit_gen;
   logic hit_ptr;
   logic hit_hib;
   logic hit_lob;
   logic hit_seg;
   logic hit_mem;
   logic mapped;
   logic [1:0] fidx;
   logic [2:0] mem_idx;
   logic [1:0] mem_be;
   logic [15:0] mem_wdata;
   logic [15:0] mem_q;
   logic mem_we;
   logic [7:0] pins;
   logic [7:0] events;
   logic halt_now;
   logic abort_req;
   logic [15:0] wr16;
   logic [1:0] strb16;

   assign setup_edge = PSEL && !PENABLE;
   assign first_acc = PSEL && PENABLE && !s.ack;
   assign done_wr = PSEL && PENABLE && s.ack && PWRITE;
   assign hit_gen = in_file(PADDR, ESB_OFS_GEN);
   assign hit_ptr = in_file(PADDR, ESB_OFS_PTR);
   assign hit_hib = in_file(PADDR, ESB_OFS_HIB);
   assign hit_lob = in_file(PADDR, ESB_OFS_LOB);
   assign hit_seg = in_file(PADDR, ESB_OFS_SEG);
   assign hit_mem = hit_gen || hit_ptr || hit_hib || hit_lob;
   assign fidx = PADDR[3:2];
   assign wr16 = PWDATA[15:0];
   assign strb16 = PSTRB[1:0];
   assign mapped = hit_mem || hit_seg || (PADDR == ESB_OFS_INSTR) || (PADDR == ESB_OFS_FLAGS)
                   || (PADDR == ESB_OFS_OPCODE) || (PADDR == ESB_OFS_PREV)
                   || (PADDR == ESB_OFS_TLO) || (PADDR == ESB_OFS_THI)
                   || (PADDR == ESB_OFS_FRAMES) || (PADDR == ESB_OFS_CAUSE)
                   || (PADDR == ESB_OFS_PINS) || (PADDR == ESB_OFS_CTRL);

   // byte files share storage with the general words
   always_comb begin
      mem_idx = hit_ptr ? (ESB_MEM_PTR_BASE + {1'b0, fidx}) : {1'b0, fidx};
      mem_be = strb16;
      mem_wdata = wr16;
      if (hit_hib) begin
         mem_be = {PSTRB[0], 1'b0}; // R01
         mem_wdata = {PWDATA[7:0], 8'h00};
      end else if (hit_lob) begin
         mem_be = {1'b0, PSTRB[0]}; // R01
         mem_wdata = {8'h00, PWDATA[7:0]};
      end
   end

   assign mem_we = done_wr && hit_mem;

   esb_regmem #(
      .DW(16),
      .DEPTH(8),
      .AW(3)
   ) u_regmem (
      .clk(CLK),
      .rst(RST),
      .we(mem_we),
      .be(mem_be),
      .waddr(mem_idx),
      .wdata(mem_wdata),
      .raddr(mem_idx),
      .rdata(mem_q)
   );

   assign pins = {REQUEST_GRANT_STATUS, INTERRUPT_REQUEST_PIN, MIN_MAX_STRAP, PIN_RESET,
                  PIN_HOLD, PIN_TEST, PIN_NMI, PIN_READY}; // R22

   ////////////////////////////////////////////////////////////////////////////
   // halt causes

   assign abort_req = done_wr && (PADDR == ESB_OFS_CTRL) && PSTRB[0] && PWDATA[ESB_CTL_ABORT];

   always_comb begin
      events = ESB_CAUSE_NONE;
      events[ESB_C_CHAINED] = BREAK_MATCH_A && BREAK_MATCH_B; // R16
      events[ESB_C_MATCH_A] = BREAK_MATCH_A && !BREAK_MATCH_B; // R15
      events[ESB_C_MATCH_B] = BREAK_MATCH_B && !BREAK_MATCH_A; // R15
      events[ESB_C_UNMAPPED] = UNMAPPED_ACCESS; // R17
      events[ESB_C_ABORT] = abort_req; // R18
      events[ESB_C_READY_TO] = READY_WAIT_EXPIRED; // R19
      events[ESB_C_HOLD_TO] = HOLD_WAIT_EXPIRED; // R20
      events[ESB_C_EXT] = EXT_HALT_LINE; // R21
   end

   assign halt_now = (s.run == ESB_RUNNING) && (events != ESB_CAUSE_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_s = s;

      // bus: one wait cycle so read data leaves a flip-flop
      if (first_acc) begin
         next_s.ack = 1'b1;
         next_s.err = !mapped;
         next_s.prdata = 32'h0000_0000;
         if (!PWRITE) begin
            if (hit_gen || hit_ptr) begin
               next_s.prdata[15:0] = mem_q;
            end else if (hit_hib) begin
               next_s.prdata[7:0] = mem_q[15:8]; // R01
            end else if (hit_lob) begin
               next_s.prdata[7:0] = mem_q[7:0]; // R01
            end else if (hit_seg) begin
               next_s.prdata[15:0] = s.seg[fidx];
            end else begin
               case (PADDR)
                  ESB_OFS_INSTR: next_s.prdata[15:0] = s.instr;
                  ESB_OFS_FLAGS: next_s.prdata[15:0] = s.flags;
                  ESB_OFS_OPCODE: next_s.prdata[7:0] = s.opcode;
                  ESB_OFS_PREV: next_s.prdata[15:0] = s.prev_ofs;
                  ESB_OFS_TLO: next_s.prdata[15:0] = s.timer[15:0]; // R07
                  ESB_OFS_THI: next_s.prdata[15:0] = s.timer[31:16]; // R08
                  ESB_OFS_FRAMES: next_s.prdata[15:0] = s.frames; // R09
                  ESB_OFS_CAUSE: next_s.prdata[7:0] = s.cause; // R14
                  ESB_OFS_PINS: next_s.prdata[7:0] = pins; // R22
                  ESB_OFS_CTRL: next_s.prdata[ESB_CTL_RUN] = (s.run == ESB_RUNNING);
                  default: next_s.prdata = 32'h0000_0000;
               endcase
            end
         end
      end else if (s.ack) begin
         next_s.ack = 1'b0;
         next_s.err = 1'b0;
      end

      // writes land at the completing edge; read-only words ignore them
      if (done_wr) begin
         if (hit_seg) begin
            next_s.seg[fidx] = merge16(s.seg[fidx], wr16, strb16);
         end else if (PADDR == ESB_OFS_INSTR) begin
            next_s.instr = merge16(s.instr, wr16, strb16);
         end else if (PADDR == ESB_OFS_FLAGS) begin
            next_s.flags = merge16(s.flags, wr16, strb16) & ESB_FLAGS_MASK; // R12 R25
         end
      end

      // flag update from the arithmetic path beats a same-cycle write
      if (ALU_VALID) begin
         next_s.flags = alu_flags(next_s.flags, ALU_A, ALU_B, ALU_SUB, ALU_BYTE); // R10 R11
      end

      // trace capture
      if (FETCH_STROBE) begin
         next_s.opcode = FETCH_OPCODE; // R05
         next_s.prev_ofs = FETCH_OFFSET; // R06
      end
      // a store in the clearing cycle counts as the first frame
      if (TRACE_CLEAR) begin
         next_s.frames = {15'h0000, FRAME_STORE}; // R09
      end else if (FRAME_STORE && (s.frames != 16'hffff)) begin
         next_s.frames = s.frames + 16'h0001; // R09
      end

      // run control and timer
      case (s.run)
         ESB_HALTED: begin
            if (done_wr && (PADDR == ESB_OFS_CTRL) && PSTRB[0] && PWDATA[ESB_CTL_RUN]) begin
               next_s.run = ESB_RUNNING;
               next_s.cause = ESB_CAUSE_NONE;
               next_s.timer = 32'h0000_0000;
               next_s.phase = 5'h00;
            end
         end
         ESB_RUNNING: begin
            // fractional prescaler: 25 MHz has no whole divide to 2 MHz
            if (s.phase + ESB_TICK_MHZ >= ESB_CLK_MHZ) begin
               next_s.phase = s.phase + ESB_TICK_MHZ - ESB_CLK_MHZ;
               next_s.timer = s.timer + 32'h0000_0001; // R07 R08
            end else begin
               next_s.phase = s.phase + ESB_TICK_MHZ;
            end
            if (halt_now) begin
               next_s.run = ESB_HALTED;
               next_s.cause = one_cause(events); // R14 R23
            end
         end
         default: next_s.run = ESB_HALTED;
      endcase

      // address formation
      next_s.fetch_addr = phys_addr(s.seg[ESB_SEG_CS], s.instr); // R02
      if (REF_USES_STACK) begin
         next_s.data_addr = phys_addr(s.seg[ESB_SEG_SS], REF_OFFSET); // R04
      end else if (REF_STRING_DEST) begin
         next_s.data_addr = phys_addr(s.seg[ESB_SEG_EXTRA], REF_OFFSET); // R03
      end else begin
         next_s.data_addr = phys_addr(s.seg[ESB_SEG_DATA], REF_OFFSET); // R03
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s <= '0;
         s.run <= ESB_HALTED;
         s.flags <= ESB_FLAGS_RST;
         s.cause <= ESB_CAUSE_NONE; // R24
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign PRDATA = s.prdata;
   assign PREADY = PSEL && PENABLE && s.ack;
   assign PSLVERR = PSEL && PENABLE && s.ack && s.err;
   assign FETCH_ADDR = s.fetch_addr;
   assign DATA_ADDR = s.data_addr;
   assign EMU_RUNNING = (s.run == ESB_RUNNING);
   assign SINGLE_STEP = s.flags[ESB_FL_TF]; // R13
endmodule // esb_emu_status
`default_nettype wire

//--- design/esb_regmem.sv
`default_nettype none
module esb_regmem #(
   parameter int DW = 16,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write port with byte enables
   input wire logic we,
   input wire logic [1:0] be,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // registered read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;
      logic [DW-1:0] q;
   } esb_mem_t;

   esb_mem_t s;
   esb_mem_t next_s;

   always_comb begin
      next_s = s;
      // read before write: same-cycle write shows on the next read
      next_s.q = s.mem[raddr];
      if (we && be[1]) begin
         next_s.mem[waddr][DW-1:DW/2] = wdata[DW-1:DW/2];
      end
      if (we && be[0]) begin
         next_s.mem[waddr][DW/2-1:0] = wdata[DW/2-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.q;
endmodule // esb_regmem
`default_nettype wire

//--- include/esb_pkg.sv
`default_nettype none
package esb_pkg;
   // register byte addresses on the bus
   localparam int ESB_AW = 8;
   localparam logic [7:0] ESB_OFS_GEN = 8'h00;
   localparam logic [7:0] ESB_OFS_PTR = 8'h10;
   localparam logic [7:0] ESB_OFS_SEG = 8'h20;
   localparam logic [7:0] ESB_OFS_INSTR = 8'h30;
   localparam logic [7:0] ESB_OFS_FLAGS = 8'h34;
   localparam logic [7:0] ESB_OFS_OPCODE = 8'h38;
   localparam logic [7:0] ESB_OFS_PREV = 8'h3c;
   localparam logic [7:0] ESB_OFS_HIB = 8'h40;
   localparam logic [7:0] ESB_OFS_LOB = 8'h50;
   localparam logic [7:0] ESB_OFS_TLO = 8'h60;
   localparam logic [7:0] ESB_OFS_THI = 8'h64;
   localparam logic [7:0] ESB_OFS_FRAMES = 8'h68;
   localparam logic [7:0] ESB_OFS_CAUSE = 8'h6c;
   localparam logic [7:0] ESB_OFS_PINS = 8'h70;
   localparam logic [7:0] ESB_OFS_CTRL = 8'h74;
   // four word registers per file, one word apart
   localparam logic [7:0] ESB_FILE_SPAN = 8'h10;
   // flags word bit positions
   localparam int ESB_FL_CF = 0;
   localparam int ESB_FL_PF = 2;
   localparam int ESB_FL_AF = 4;
   localparam int ESB_FL_ZF = 6;
   localparam int ESB_FL_SF = 7;
   localparam int ESB_FL_TF = 8;
   localparam int ESB_FL_IF = 9;
   localparam int ESB_FL_DF = 10;
   localparam int ESB_FL_OF = 11;
   localparam logic [15:0] ESB_FLAGS_MASK = 16'h0fd5;
   localparam logic [15:0] ESB_FLAGS_RST = 16'h0000;
   // halt reason bit positions
   localparam int ESB_C_MATCH_A = 0;
   localparam int ESB_C_MATCH_B = 1;
   localparam int ESB_C_CHAINED = 2;
   localparam int ESB_C_UNMAPPED = 3;
   localparam int ESB_C_ABORT = 4;
   localparam int ESB_C_READY_TO = 5;
   localparam int ESB_C_HOLD_TO = 6;
   localparam int ESB_C_EXT = 7;
   localparam logic [7:0] ESB_CAUSE_NONE = 8'h00;
   // control register bits
   localparam int ESB_CTL_RUN = 0;
   localparam int ESB_CTL_ABORT = 1;
   // segment and pointer file indices
   localparam logic [1:0] ESB_SEG_CS = 2'h0;
   localparam logic [1:0] ESB_SEG_DATA = 2'h1;
   localparam logic [1:0] ESB_SEG_SS = 2'h2;
   localparam logic [1:0] ESB_SEG_EXTRA = 2'h3;
   localparam logic [2:0] ESB_MEM_PTR_BASE = 3'h4;
   // elapsed timer: 2 MHz ticks from the 25 MHz clock
   localparam logic [4:0] ESB_CLK_MHZ = 5'h19;
   localparam logic [4:0] ESB_TICK_MHZ = 5'h02;
   typedef enum logic {ESB_HALTED, ESB_RUNNING} esb_run_t;
endpackage
`default_nettype wire

//--- test/esb_emu_status_props.sv
`default_nettype none
module esb_emu_status_props (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // register bus
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [esb_pkg::ESB_AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // halt inputs
   input wire logic BREAK_MATCH_A,
   input wire logic EXT_HALT_LINE,
   // processor pins
   input wire logic PIN_READY,
   input wire logic PIN_NMI,
   input wire logic PIN_TEST,
   input wire logic PIN_HOLD,
   input wire logic PIN_RESET,
   input wire logic MIN_MAX_STRAP,
   input wire logic INTERRUPT_REQUEST_PIN,
   input wire logic REQUEST_GRANT_STATUS,
   // status
   input wire logic EMU_RUNNING,
   input wire logic SINGLE_STEP
);
   import esb_pkg::*;
   logic done, rd_done, ctl_wr;
   logic [7:0] pins;
   assign done = PSEL && PENABLE && PREADY;
   assign rd_done = done && !PWRITE;
   assign ctl_wr = done && PWRITE && PADDR == ESB_OFS_CTRL && PSTRB[0];
   assign pins = {REQUEST_GRANT_STATUS, INTERRUPT_REQUEST_PIN, MIN_MAX_STRAP, PIN_RESET,
      PIN_HOLD, PIN_TEST, PIN_NMI, PIN_READY};
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////////////////////////
   chk_ready_wait: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
      else $error("late ready");
   chk_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   chk_halt_match: assert property (EMU_RUNNING && BREAK_MATCH_A |=> !EMU_RUNNING)
      else $error("match did not halt");
   chk_halt_ext: assert property (EMU_RUNNING && EXT_HALT_LINE |=> !EMU_RUNNING)
      else $error("ext line no halt");
   chk_stay_halted: assert property
      (!EMU_RUNNING && !(ctl_wr && PWDATA[ESB_CTL_RUN]) |=> !EMU_RUNNING)
      else $error("run without start");
   chk_abort_halt: assert property
      (EMU_RUNNING && ctl_wr && PWDATA[ESB_CTL_ABORT] |=> !EMU_RUNNING)
      else $error("abort did not halt");
   chk_cause_single: assert property
      (rd_done && PADDR == ESB_OFS_CAUSE |-> $onehot0(PRDATA[7:0]) && PRDATA[31:8] == 0)
      else $error("several causes");
   chk_pin_read: assert property
      (rd_done && PADDR == ESB_OFS_PINS |-> PRDATA[7:0] == $past(pins))
      else $error("pin word wrong");
   chk_flag_layout: assert property
      (rd_done && PADDR == ESB_OFS_FLAGS |-> (PRDATA[15:0] & ~ESB_FLAGS_MASK) == 16'h0000)
      else $error("reserved flag bit set");
   chk_trap_step: assert property
      (done && PWRITE && PADDR == ESB_OFS_FLAGS && PSTRB[1]
       |=> SINGLE_STEP == $past(PWDATA[ESB_FL_TF]))
      else $error("step differs from trap");
   cov_ext_halt: cover property (EMU_RUNNING && EXT_HALT_LINE);
   cov_slverr: cover property (PSLVERR);
   cov_cause_read: cover property (rd_done && PADDR == ESB_OFS_CAUSE && PRDATA[7:0] != 8'h00);
endmodule // esb_emu_status_props

bind esb_emu_status esb_emu_status_props u_props (.*);
`default_nettype wire

//--- test/esb_emu_status_test.sv
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
   $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module esb_emu_status_test;
   timeunit 1ns;
   timeprecision 1ns;
   import esb_pkg::*;
   logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [3:0] PSTRB = 4'hf;
   logic [15:0] REF_OFFSET = 16'h0005;
   logic REF_USES_STACK = 1'b0, REF_STRING_DEST = 1'b0;
   logic PREADY, PSLVERR, EMU_RUNNING, SINGLE_STEP, fs, st, cl, av, sb, by, err;
   logic [31:0] PRDATA, rd, ticks;
   logic [7:0] op, hr, pn;
   logic [15:0] ofs, aa, ab;
   logic [19:0] FETCH_ADDR, DATA_ADDR;
   logic [15:0] a_tab[5] = '{16'h000f, 16'hffff, 16'h0000, 16'h7fff, 16'h00ff};
   logic [15:0] f_tab[5] = '{16'h0010, 16'h0055, 16'h0095, 16'h0894, 16'h0055};
   int fail_count = 0;
   int total_checks = 0;
   always #20 CLK = ~CLK;
   esb_target_model tgt (.clk(CLK), .fetch_strobe(fs), .fetch_opcode(op), .fetch_offset(ofs),
      .frame_store(st), .trace_clear(cl), .alu_valid(av), .alu_a(aa), .alu_sub(sb),
      .alu_b(ab), .alu_byte(by), .halt_req(hr), .pins(pn));
   esb_emu_status dut (.*, .FETCH_STROBE(fs), .FETCH_OPCODE(op), .FETCH_OFFSET(ofs),
      .FRAME_STORE(st), .TRACE_CLEAR(cl), .ALU_VALID(av), .ALU_A(aa), .ALU_B(ab),
      .ALU_SUB(sb), .ALU_BYTE(by), .BREAK_MATCH_A(hr[0]), .BREAK_MATCH_B(hr[1]),
      .UNMAPPED_ACCESS(hr[3]), .READY_WAIT_EXPIRED(hr[5]), .HOLD_WAIT_EXPIRED(hr[6]),
      .EXT_HALT_LINE(hr[7]), .PIN_READY(pn[0]), .PIN_NMI(pn[1]), .PIN_TEST(pn[2]),
      .PIN_HOLD(pn[3]), .PIN_RESET(pn[4]), .MIN_MAX_STRAP(pn[5]),
      .INTERRUPT_REQUEST_PIN(pn[6]), .REQUEST_GRANT_STATUS(pn[7]));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(negedge CLK);
      while (PREADY !== 1'b1) @(negedge CLK);
      rd = PRDATA;
      err = PSLVERR;
      `CHK("ready", 1'b1, PREADY)
      @(posedge CLK);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      rdchk("cause", ESB_OFS_CAUSE, 32'h0);
      rdchk("flags", ESB_OFS_FLAGS, 32'h0);
      rdchk("timer", ESB_OFS_TLO, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(ESB_OFS_GEN + 8'(4 * i), {16'h0, 8'h10 + 8'(i), 8'h80 + 8'(i)});
         rdchk("hi byte", ESB_OFS_HIB + 8'(4 * i), 32'h10 + i);
         rdchk("lo byte", ESB_OFS_LOB + 8'(4 * i), 32'h80 + i);
         wr(ESB_OFS_HIB + 8'(4 * i), 32'h5a);
         rdchk("word", ESB_OFS_GEN + 8'(4 * i), 32'h5a80 + i);
      end
      for (int s = 0; s < 4; s++) wr(ESB_OFS_SEG + 8'(4 * s), 32'h1000 * (s + 1));
      wr(ESB_OFS_INSTR, 32'h0123);
      repeat (2) @(posedge CLK);
      @(negedge CLK);
      `CHK("fetch", 20'h10123, FETCH_ADDR)
      for (int k = 0; k < 4; k++) begin
         @(posedge CLK);
         {REF_USES_STACK, REF_STRING_DEST} <= 2'(k);
         repeat (2) @(posedge CLK);
         @(negedge CLK);
         `CHK("data", k[1] ? 20'h30005 : (k[0] ? 20'h40005 : 20'h20005), DATA_ADDR)
      end
      tgt.fetch(8'h9c, 16'h0abc);
      wr(ESB_OFS_OPCODE, 32'h11);
      rdchk("opcode", ESB_OFS_OPCODE, 32'h9c);
      rdchk("offset", ESB_OFS_PREV, 32'h0abc);
      tgt.store(3);
      wr(ESB_OFS_FRAMES, 32'h0);
      rdchk("frames", ESB_OFS_FRAMES, 32'h3);
      tgt.clear();
      rdchk("frames", ESB_OFS_FRAMES, 32'h0);
      for (int i = 0; i < 5; i++) begin
         tgt.alu(a_tab[i], 16'h0001, i == 2, i == 4);
         rdchk("flags", ESB_OFS_FLAGS, {16'h0, f_tab[i]});
      end
      wr(ESB_OFS_FLAGS, 32'hffff);
      rdchk("flags", ESB_OFS_FLAGS, {16'h0, ESB_FLAGS_MASK});
      `CHK("step", 1'b1, SINGLE_STEP)
      PSTRB <= 4'h1;
      wr(ESB_OFS_FLAGS, 32'h0);
      rdchk("flags lo", ESB_OFS_FLAGS, 32'h0f00);
      tgt.set_pins(8'ha5);
      rdchk("pins", ESB_OFS_PINS, 32'ha5);
      tgt.set_pins(8'h5a);
      rdchk("pins", ESB_OFS_PINS, 32'h5a);
      rdchk("unmapped", 8'h78, 32'h0);
      `CHK("slverr", 1'b1, err)
      for (int c = 0; c < 8; c++) begin
         wr(ESB_OFS_CTRL, 32'h1);
         rdchk("cause", ESB_OFS_CAUSE, 32'h0);
         if (c == 4) wr(ESB_OFS_CTRL, 32'h2);
         else tgt.halt(c == 2 ? 8'h03 : 8'h01 << c);
         @(negedge CLK);
         `CHK("running", 1'b0, EMU_RUNNING)
         rdchk("cause", ESB_OFS_CAUSE, 32'h1 << c);
      end
      wr(ESB_OFS_CTRL, 32'h1);
      tgt.halt(8'he0);
      rdchk("cause", ESB_OFS_CAUSE, 32'h20);
      tgt.halt(8'h80);
      rdchk("cause", ESB_OFS_CAUSE, 32'h20);
      wr(ESB_OFS_CTRL, 32'h1);
      repeat (250) @(posedge CLK);
      wr(ESB_OFS_CTRL, 32'h2);
      apb(1'b0, ESB_OFS_TLO, 32'h0);
      `CHK("span", 1'b1, rd >= 32'd19 && rd <= 32'd22)
      ticks = rd;
      wr(ESB_OFS_TLO, 32'h0);
      rdchk("timer", ESB_OFS_TLO, ticks);
      rdchk("timer hi", ESB_OFS_THI, 32'h0);
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge CLK);
      fail_count++;
      $display("MISMATCH watchdog expected end seen hang");
      report_and_stop();
   end
endmodule // esb_emu_status_test
`default_nettype wire

//--- test/esb_target_model.sv
`default_nettype none
module esb_target_model (
   // clock
   input wire logic clk,
   // trace capture
   output logic fetch_strobe,
   output logic [7:0] fetch_opcode,
   output logic [15:0] fetch_offset,
   output logic frame_store,
   output logic trace_clear,
   // arithmetic
   output logic alu_valid,
   output logic [15:0] alu_a,
   output logic [15:0] alu_b,
   output logic alu_sub,
   output logic alu_byte,
   // halt conditions
   output logic [7:0] halt_req,
   // processor pins
   output logic [7:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {fetch_strobe, fetch_opcode, fetch_offset, frame_store, trace_clear} = '0;
      {alu_valid, alu_a, alu_b, alu_sub, alu_byte, halt_req, pins} = '0;
   end
   task automatic fetch(input logic [7:0] op, input logic [15:0] ofs);
      @(posedge clk);
      fetch_strobe <= 1'b1;
      fetch_opcode <= op;
      fetch_offset <= ofs;
      @(posedge clk);
      fetch_strobe <= 1'b0;
      fetch_opcode <= ~op;
      fetch_offset <= ~ofs;
   endtask
   task automatic store(input int n);
      @(posedge clk);
      frame_store <= 1'b1;
      repeat (n) @(posedge clk);
      frame_store <= 1'b0;
   endtask
   task automatic clear();
      @(posedge clk);
      trace_clear <= 1'b1;
      @(posedge clk);
      trace_clear <= 1'b0;
   endtask
   task automatic alu(input logic [15:0] a, input logic [15:0] b, input logic sub,
                      input logic byt);
      @(posedge clk);
      alu_valid <= 1'b1;
      alu_a <= a;
      alu_b <= b;
      alu_sub <= sub;
      alu_byte <= byt;
      @(posedge clk);
      alu_valid <= 1'b0;
      alu_a <= ~a;
      alu_b <= ~b;
   endtask
   task automatic halt(input logic [7:0] m);
      @(posedge clk);
      halt_req <= m;
      @(posedge clk);
      halt_req <= 8'h00;
   endtask
   task automatic set_pins(input logic [7:0] p);
      @(posedge clk);
      pins <= p;
   endtask
endmodule // esb_target_model
`default_nettype wire
